//--- bench/psv_core_model.sv
// Behavioural protection core on the cascade path: takes egress beats and returns them on ingress.
// Assumes the one bench clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module psv_core_model #(
  parameter int unsigned   DW  = 48,
  parameter logic [DW-1:0] KEY = '0,
  parameter int unsigned   LAT = 3
) (
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic [DW-1:0]      egress_tdata,
  input  wire psv_pkg::psv_side_t egress_side,
  input  wire logic               egress_tvalid,
  output var  logic               egress_tready,
  output var  logic [DW-1:0]      ingress_tdata,
  output var  psv_pkg::psv_side_t ingress_side,
  output var  logic               ingress_tvalid,
  input  wire logic               ingress_tready
);
  logic               full_q;
  logic [7:0]         wait_q;
  logic [DW-1:0]      data_q;
  psv_pkg::psv_side_t side_q;

  // Stand-in for decryption: XOR with a fixed pattern, ingress valid LAT+1 cycles after the beat is taken
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      full_q         <= 1'b0;
      wait_q         <= 8'h00;
      ingress_tvalid <= 1'b0;
    end else if (!full_q) begin
      if (egress_tvalid) begin
        full_q <= 1'b1;
        data_q <= egress_tdata ^ KEY;
        side_q <= egress_side;
        wait_q <= 8'(LAT);
      end
    end else if (wait_q != 8'h00) begin
      wait_q <= wait_q - 8'h01;
    end else if (!ingress_tvalid) begin
      ingress_tvalid <= 1'b1;
    end else if (ingress_tready) begin
      ingress_tvalid <= 1'b0;
      full_q         <= 1'b0;
    end
  end

  assign egress_tready = !full_q;
  // Idle ingress shows a changed pattern, never the last beat
  assign ingress_tdata = ingress_tvalid ? data_q : ~data_q;
  assign ingress_side  = ingress_tvalid ? side_q : psv_pkg::psv_side_t'(~side_q);
endmodule
`default_nettype wire

//--- bench/psv_top_tb.sv
// Self-checking bench for the protection switch: control port, DDC snooping, cascade video path.
// Assumes psv_top with both cores, stream mode, BPC 8 and PPC 2.
`timescale 1ns/1ps
`default_nettype none
module psv_top_tb;
  localparam int unsigned   DW  = psv_pkg::psv_data_width(8, 2);
  localparam logic [DW-1:0] KEY = 48'h5A5A_0F0F_A5A5;
  logic clock, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [8:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, core_enable;
  logic ddc_scl_i, ddc_sda_i, link_tvalid, link_tready, egress_tvalid, egress_tready;
  logic ingress_tvalid, ingress_tready, detect_irq, video_tvalid, video_tready;
  logic video_tlast, video_tuser, native_active_video, native_hsync, native_field;
  logic [DW-1:0] link_tdata, egress_tdata, ingress_tdata, video_tdata, native_data;
  psv_pkg::psv_side_t  link_side, egress_side, ingress_side;
  psv_pkg::psv_proto_t detected_proto;
  int n_fail, comparisons;
  logic [31:0] rd;
  logic [1:0]  resp;
  logic [7:0] tbl_dev [8] = '{8'h75, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'hA0};
  logic [7:0] tbl_offs[8] = '{8'h10, 8'h44, 8'h00, 8'h50, 8'hC0, 8'h48, 8'hC1, 8'h10};
  logic [1:0] tbl_prot[8] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
  logic       tbl_irq [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  psv_top u_psv_top (
    .clock(clock), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ddc_scl_i(ddc_scl_i), .ddc_sda_i(ddc_sda_i),
    .link_tdata(link_tdata), .link_side(link_side), .link_tvalid(link_tvalid),
    .link_tready(link_tready), .egress_tdata(egress_tdata), .egress_side(egress_side),
    .egress_tvalid(egress_tvalid), .egress_tready(egress_tready), .ingress_tdata(ingress_tdata),
    .ingress_side(ingress_side), .ingress_tvalid(ingress_tvalid), .ingress_tready(ingress_tready),
    .core_enable(core_enable), .detect_irq(detect_irq), .detected_proto(detected_proto),
    .video_tdata(video_tdata), .video_tvalid(video_tvalid), .video_tready(video_tready),
    .video_tlast(video_tlast), .video_tuser(video_tuser), .native_data(native_data),
    .native_active_video(native_active_video), .native_hsync(native_hsync),
    .native_field(native_field)
  );

  psv_core_model #(.DW(DW), .KEY(KEY), .LAT(3)) u_psv_core_model (
    .clock(clock), .reset_n(reset_n), .egress_tdata(egress_tdata), .egress_side(egress_side),
    .egress_tvalid(egress_tvalid), .egress_tready(egress_tready), .ingress_tdata(ingress_tdata),
    .ingress_side(ingress_side), .ingress_tvalid(ingress_tvalid), .ingress_tready(ingress_tready)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Single-beat write, held until taken, response taken with bready high
  task automatic axi_write(input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr  = a;
    s_axi_wdata   = d;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid  = 1'b1;
    #1;
    while (s_axi_awready !== 1'b1 && n < 50) begin
      @(negedge clock);
      #1;
      n++;
    end
    @(negedge clock);
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    resp = s_axi_bresp;
    check(s_axi_bvalid, 1'b1);
    @(negedge clock);
    check(s_axi_bvalid, 1'b0);
  endtask

  task automatic axi_read(input logic [8:0] a);
    int n;
    n = 0;
    s_axi_araddr  = a;
    s_axi_arvalid = 1'b1;
    #1;
    while (s_axi_arready !== 1'b1 && n < 50) begin
      @(negedge clock);
      #1;
      n++;
    end
    @(negedge clock);
    s_axi_arvalid = 1'b0;
    rd   = s_axi_rdata;
    resp = s_axi_rresp;
    check(s_axi_rvalid, 1'b1);
    @(negedge clock);
    check(s_axi_rvalid, 1'b0);
  endtask

  // SDA only moves while SCL is low, except for start and stop
  task automatic ddc_bit(input logic v);
    ddc_scl_i = 1'b0;
    repeat (2) @(negedge clock);
    ddc_sda_i = v;
    repeat (2) @(negedge clock);
    ddc_scl_i = 1'b1;
    repeat (4) @(negedge clock);
  endtask

  // Start, device byte, offset byte, each acked by the sink, then stop
  task automatic ddc_xfer(input logic [7:0] dev, input logic [7:0] offs);
    logic [15:0] bits;
    bits = {dev, offs};
    ddc_sda_i = 1'b0;
    repeat (4) @(negedge clock);
    for (int i = 15; i >= 0; i--) begin
      ddc_bit(bits[i]);
      if (i % 8 == 0) ddc_bit(1'b0);
    end
    ddc_bit(1'b0);
    ddc_sda_i = 1'b1;
    repeat (6) @(negedge clock);
  endtask

  // One beat in, held output checked under stall, then released
  task automatic beat(input logic [DW-1:0] d, input logic sof, input logic eol,
                      input logic [DW-1:0] exp);
    int n;
    n = 0;
    link_tdata  = d;
    link_side   = psv_pkg::psv_side_t'({eol, sof, 2'b00});
    link_tvalid = 1'b1;
    #1;
    check(egress_tdata, d);
    while (link_tready !== 1'b1 && n < 50) begin
      @(negedge clock);
      #1;
      n++;
    end
    @(negedge clock);
    link_tvalid = 1'b0;
    while (video_tvalid !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    repeat (3) @(negedge clock);
    check(video_tvalid, 1'b1);
    check(video_tdata, exp);
    check(video_tlast, eol);
    check(video_tuser, sof);
    check({native_active_video, native_hsync, native_field}, 3'h0);
    video_tready = 1'b1;
    @(negedge clock);
    video_tready = 1'b0;
    check(video_tvalid, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check(DW, 48);
    check(core_enable, 2'h0);
    check(detect_irq, 1'b0);
    check(native_data, '0);
    axi_read(psv_pkg::PSV_REG_STAT);
    check(rd, 32'h0000_0000);
    axi_write(9'h100, 32'h0000_0003);
    check(resp, psv_pkg::PSV_RESP_SLV);
    axi_read(9'h100);
    check({rd, resp}, {32'h0, psv_pkg::PSV_RESP_SLV});
    $display("test reset and unmapped done");
  endtask

  task automatic t_detect();
    for (int i = 0; i < 8; i++) begin
      axi_write(psv_pkg::PSV_REG_STAT, 32'h0000_0001);
      check(detect_irq, 1'b0);
      ddc_xfer(tbl_dev[i], tbl_offs[i]);
      check(detect_irq, tbl_irq[i]);
      check(detected_proto, tbl_prot[i]);
      axi_read(psv_pkg::PSV_REG_STAT);
      check(rd, {29'h0, tbl_prot[i], tbl_irq[i]});
    end
    $display("test detection done");
  endtask

  task automatic t_cascade();
    for (int c = 0; c < 2; c++) begin
      axi_write(psv_pkg::PSV_REG_CTRL, 32'h0000_0000);
      check(core_enable, 2'h0);
      axi_write(psv_pkg::PSV_REG_CTRL, 32'h1 << c);
      check(core_enable, 2'h1 << c);
      beat(48'h1234_5678_9ABC, 1'b1, 1'b0, 48'h1234_5678_9ABC ^ KEY);
      beat(48'hFEDC_BA98_7654, 1'b0, 1'b1, 48'hFEDC_BA98_7654 ^ KEY);
    end
    axi_write(psv_pkg::PSV_REG_CTRL, 32'h0000_0000);
    beat(48'h0F0F_3C3C_AAAA, 1'b1, 1'b1, 48'h0F0F_3C3C_AAAA);
    $display("test cascade path done");
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    #100000;
    n_fail++;
    complete_run();
  end

  initial begin
    n_fail = 0;
    comparisons = 0;
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
    s_axi_awaddr = 9'h000;
    s_axi_araddr = 9'h000;
    s_axi_wdata  = 32'h0000_0000;
    s_axi_wstrb  = 4'hF;
    ddc_scl_i    = 1'b1;
    ddc_sda_i    = 1'b1;
    link_tdata   = '0;
    link_side    = psv_pkg::psv_side_t'(4'h0);
    link_tvalid  = 1'b0;
    video_tready = 1'b0;
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    t_reset();
    t_detect();
    t_cascade();
    complete_run();
  end
endmodule
`default_nettype wire

//--- hdl/psv_pkg.sv
// Shared constants, types and helpers for the protection switch and video output block.
// Assumes a single 200 MHz clock domain for control, snooping and video paths.
package psv_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int unsigned PSV_CLK_PERIOD_PS = 5000;

  // ----------------------------------------------------------------
  // Display data channel snooping
  // ----------------------------------------------------------------
  // 8-bit bus address 0x74 seen as a 7-bit device address
  localparam logic [6:0] PSV_DDC_DEV_ADDR = 7'h3A;
  localparam logic [7:0] PSV_V1_OFFS_LO   = 8'h00;
  localparam logic [7:0] PSV_V1_OFFS_HI   = 8'h44;
  localparam logic [7:0] PSV_V2_OFFS_LO   = 8'h50;
  localparam logic [7:0] PSV_V2_OFFS_HI   = 8'hC0;
  localparam logic [3:0] PSV_ACK_BIT      = 4'h8;

  // ----------------------------------------------------------------
  // Control port map
  // ----------------------------------------------------------------
  localparam int unsigned PSV_AXI_AW    = 9;
  localparam int unsigned PSV_AXI_DW    = 32;
  localparam logic [8:0]  PSV_REG_CTRL  = 9'h000;
  localparam logic [8:0]  PSV_REG_STAT  = 9'h004;
  localparam int unsigned PSV_CTRL_V1   = 0;
  localparam int unsigned PSV_CTRL_V2   = 1;
  localparam logic [1:0]  PSV_CTRL_RST  = 2'h0;
  localparam int unsigned PSV_STAT_PEND = 0;
  localparam int unsigned PSV_STAT_PROT = 1;
  localparam logic [1:0]  PSV_RESP_OKAY = 2'h0;
  localparam logic [1:0]  PSV_RESP_SLV  = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSV_PROTO_NONE = 2'h0,
    PSV_PROTO_V1   = 2'h1,
    PSV_PROTO_V2   = 2'h2
  } psv_proto_t;

  typedef enum logic [5:0] {
    PSV_ST_IDLE   = 6'h01,
    PSV_ST_ADDR   = 6'h02,
    PSV_ST_OFFS   = 6'h04,
    PSV_ST_WDATA  = 6'h08,
    PSV_ST_RDATA  = 6'h10,
    PSV_ST_IGNORE = 6'h20
  } psv_ddc_st_t;

  // Side-band that travels with every video beat
  typedef struct packed {
    logic eol;
    logic sof;
    logic hsync;
    logic field;
  } psv_side_t;

  // Byte-rounded video width
  function automatic int unsigned psv_data_width(input int unsigned bpc,
                                                 input int unsigned ppc);
    psv_data_width = ((3 * bpc * ppc + 7) / 8) * 8;
  endfunction

endpackage

//--- hdl/psv_sync2.sv
// Two-flop level synchroniser.
// Assumes the input is asynchronous to clock; only the second flop is read outside.
`timescale 1ns/1ps
`default_nettype none
module psv_sync2 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta_q;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

//--- hdl/psv_top.sv
// Protection protocol switch, cascade routing and video output.
// Assumes DDC pins are asynchronous; streams and control share the one clock.
//
// Operation
// - Both protocol cores present: they are chained in one cascade path.
// - Encrypted beats leave on egress; decrypted beats return on ingress to output.
// - Protocol detected by snooping DDC transfers to device address 0x74.
// - Offsets 0x00 to 0x44 classify as the older protocol.
// - Offsets 0x50 to 0xC0 classify as the newer protocol.
// - Every detection event raises the interrupt.
// - Single configured protocol: no detection, that protocol always in use.
// - AXI4-Lite control slave, 9-bit addresses, 32-bit data.
// - Stream mode: AXI4-Stream master, TLAST ends line, TUSER starts frame.
// - Data width is three times BPC times PPC rounded up to bytes.
// - Width fixed at build time by BPC and PPC parameters.
// - Native mode drives data, active video and horizontal sync.
// - Native mode drives a field identifier for interlaced video.
// - DDC follows I2C signalling.
`timescale 1ns/1ps
`default_nettype none
module psv_top #(
  parameter bit          HAS_V1      = 1'b1,
  parameter bit          HAS_V2      = 1'b1,
  parameter bit          NATIVE_MODE = 1'b0,
  parameter int unsigned BPC         = 8,
  parameter int unsigned PPC         = 2,
  localparam int unsigned DW         = psv_pkg::psv_data_width(BPC, PPC)
) (
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  input  wire logic [8:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [8:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      ddc_scl_i,
  input  wire logic                      ddc_sda_i,
  input  wire logic [DW-1:0]             link_tdata,
  input  wire psv_pkg::psv_side_t        link_side,
  input  wire logic                      link_tvalid,
  output var  logic                      link_tready,
  output var  logic [DW-1:0]             egress_tdata,
  output var  psv_pkg::psv_side_t        egress_side,
  output var  logic                      egress_tvalid,
  input  wire logic                      egress_tready,
  input  wire logic [DW-1:0]             ingress_tdata,
  input  wire psv_pkg::psv_side_t        ingress_side,
  input  wire logic                      ingress_tvalid,
  output var  logic                      ingress_tready,
  output var  logic [1:0]                core_enable,
  output var  logic                      detect_irq,
  output var  psv_pkg::psv_proto_t       detected_proto,
  output var  logic [DW-1:0]             video_tdata,
  output var  logic                      video_tvalid,
  input  wire logic                      video_tready,
  output var  logic                      video_tlast,
  output var  logic                      video_tuser,
  output var  logic [DW-1:0]             native_data,
  output var  logic                      native_active_video,
  output var  logic                      native_hsync,
  output var  logic                      native_field
);

  localparam bit BOTH = HAS_V1 && HAS_V2;

  // ----------------------------------------------------------------
  // DDC snooping
  // ----------------------------------------------------------------
  logic                 scl_s, sda_s, scl_d_q, sda_d_q;
  logic                 scl_rise, bus_start, bus_stop, byte_done;
  logic [3:0]           bitcnt_q;
  logic [7:0]           shift_q, ptr_q, class_offs;
  psv_pkg::psv_ddc_st_t state_q;
  logic                 det_event;
  psv_pkg::psv_proto_t  det_proto;

  psv_sync2 #(.RESET_VAL(1'b1)) u_sync_scl (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in (ddc_scl_i),
    .sync_out (scl_s)
  );

  psv_sync2 #(.RESET_VAL(1'b1)) u_sync_sda (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in (ddc_sda_i),
    .sync_out (sda_s)
  );

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  // Start and stop are SDA edges while SCL stays high
  assign scl_rise  = scl_s & ~scl_d_q;
  assign bus_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign bus_stop  = scl_s & scl_d_q & ~sda_d_q & sda_s;
  assign byte_done = scl_rise && bitcnt_q == psv_pkg::PSV_ACK_BIT
                     && state_q != psv_pkg::PSV_ST_IDLE
                     && state_q != psv_pkg::PSV_ST_IGNORE;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q  <= psv_pkg::PSV_ST_IDLE;
      bitcnt_q <= 4'h0;
      shift_q  <= 8'h00;
      ptr_q    <= 8'h00;
    end else if (bus_start) begin
      state_q  <= psv_pkg::PSV_ST_ADDR;
      bitcnt_q <= 4'h0;
    end else if (bus_stop) begin
      state_q  <= psv_pkg::PSV_ST_IDLE;
    end else if (byte_done) begin
      bitcnt_q <= 4'h0;
      unique case (state_q)
        psv_pkg::PSV_ST_ADDR: begin
          if (shift_q[7:1] != psv_pkg::PSV_DDC_DEV_ADDR) begin
            state_q <= psv_pkg::PSV_ST_IGNORE;
          end else if (shift_q[0]) begin
            state_q <= psv_pkg::PSV_ST_RDATA;
          end else begin
            state_q <= psv_pkg::PSV_ST_OFFS;
          end
        end
        psv_pkg::PSV_ST_OFFS: begin
          ptr_q   <= shift_q;
          state_q <= psv_pkg::PSV_ST_WDATA;
        end
        psv_pkg::PSV_ST_WDATA: begin
          ptr_q <= ptr_q + 8'h01;
        end
        psv_pkg::PSV_ST_RDATA: begin
          ptr_q <= ptr_q + 8'h01;
          // A NACK from the reader ends the read
          if (sda_s) begin
            state_q <= psv_pkg::PSV_ST_IGNORE;
          end
        end
        default: begin
          state_q <= psv_pkg::PSV_ST_IDLE;
        end
      endcase
    end else if (scl_rise && state_q != psv_pkg::PSV_ST_IDLE
                 && state_q != psv_pkg::PSV_ST_IGNORE) begin
      shift_q  <= {shift_q[6:0], sda_s};
      bitcnt_q <= bitcnt_q + 4'h1;
    end
  end

  // Classify the offset of every access aimed at the protection slave
  always_comb begin
    class_offs = (state_q == psv_pkg::PSV_ST_OFFS) ? shift_q : ptr_q;
    det_proto  = psv_pkg::PSV_PROTO_NONE;
    if (class_offs <= psv_pkg::PSV_V1_OFFS_HI) begin
      det_proto = psv_pkg::PSV_PROTO_V1;
    end else if (class_offs >= psv_pkg::PSV_V2_OFFS_LO
                 && class_offs <= psv_pkg::PSV_V2_OFFS_HI) begin
      det_proto = psv_pkg::PSV_PROTO_V2;
    end
    det_event = BOTH && byte_done && state_q != psv_pkg::PSV_ST_ADDR
                && det_proto != psv_pkg::PSV_PROTO_NONE;
  end

  // ----------------------------------------------------------------
  // Control and status
  // ----------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic       pend_q;
  logic       wr_go, pend_clr, aw_hit_ctrl, aw_hit_stat;

  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = ~s_axi_rvalid;
  assign aw_hit_ctrl   = s_axi_awaddr == psv_pkg::PSV_REG_CTRL;
  assign aw_hit_stat   = s_axi_awaddr == psv_pkg::PSV_REG_STAT;
  assign pend_clr      = wr_go & aw_hit_stat & s_axi_wstrb[0]
                         & s_axi_wdata[psv_pkg::PSV_STAT_PEND];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_q       <= psv_pkg::PSV_CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= psv_pkg::PSV_RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_hit_ctrl || aw_hit_stat) ? psv_pkg::PSV_RESP_OKAY
                                                     : psv_pkg::PSV_RESP_SLV;
        if (aw_hit_ctrl && s_axi_wstrb[0]) begin
          ctrl_q <= s_axi_wdata[1:0];
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= psv_pkg::PSV_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= psv_pkg::PSV_RESP_OKAY;
      if (s_axi_araddr == psv_pkg::PSV_REG_CTRL) begin
        s_axi_rdata <= {30'h0000_0000, ctrl_q};
      end else if (s_axi_araddr == psv_pkg::PSV_REG_STAT) begin
        s_axi_rdata <= {29'h0000_0000, detected_proto, pend_q};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= psv_pkg::PSV_RESP_SLV;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Detection wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pend_q         <= 1'b0;
      detected_proto <= psv_pkg::PSV_PROTO_NONE;
    end else begin
      if (det_event) begin
        pend_q         <= 1'b1;
        detected_proto <= det_proto;
      end else if (pend_clr) begin
        pend_q <= 1'b0;
      end
    end
  end

  assign detect_irq = pend_q;

  // ----------------------------------------------------------------
  // Cascade routing
  // ----------------------------------------------------------------
  logic out_ready, cascade;

  // A lone configured core is always the one in use
  assign core_enable[psv_pkg::PSV_CTRL_V1] = HAS_V1 && (!BOTH || ctrl_q[psv_pkg::PSV_CTRL_V1]);
  assign core_enable[psv_pkg::PSV_CTRL_V2] = HAS_V2 && (!BOTH || ctrl_q[psv_pkg::PSV_CTRL_V2]);
  assign cascade = |core_enable;

  // Without an active core the link bypasses egress and ingress
  assign egress_tdata   = link_tdata;
  assign egress_side    = link_side;
  assign egress_tvalid  = cascade & link_tvalid;
  assign link_tready    = cascade ? egress_tready : out_ready;
  assign ingress_tready = cascade & out_ready;

  // ----------------------------------------------------------------
  // Video output stage
  // ----------------------------------------------------------------
  logic               src_valid;
  logic [DW-1:0]      src_data;
  psv_pkg::psv_side_t src_side, out_side_q;
  logic [DW-1:0]      out_data_q;
  logic               out_valid_q;

  assign src_valid = cascade ? ingress_tvalid : link_tvalid;
  assign src_data  = cascade ? ingress_tdata : link_tdata;
  assign src_side  = cascade ? ingress_side : link_side;
  assign out_ready = NATIVE_MODE || !out_valid_q || video_tready;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
      out_side_q  <= '0;
    end else if (out_ready) begin
      out_valid_q <= src_valid;
      out_side_q  <= src_valid ? src_side : '0;
      if (src_valid) begin
        out_data_q <= src_data;
      end
    end
  end

  assign video_tvalid        = !NATIVE_MODE && out_valid_q;
  assign video_tdata         = out_data_q;
  assign video_tlast         = !NATIVE_MODE && out_side_q.eol;
  assign video_tuser         = !NATIVE_MODE && out_side_q.sof;
  assign native_data         = out_data_q;
  assign native_active_video = NATIVE_MODE && out_valid_q;
  assign native_hsync        = NATIVE_MODE && out_side_q.hsync;
  assign native_field        = NATIVE_MODE && out_side_q.field;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking psv_cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_irq_on_event: assert property (det_event |=> detect_irq)
    else $error("interrupt missing after detection");
  a_old_class: assert property (BOTH && byte_done && state_q == psv_pkg::PSV_ST_OFFS
    && shift_q <= psv_pkg::PSV_V1_OFFS_HI |=> detected_proto == psv_pkg::PSV_PROTO_V1)
    else $error("older protocol offset out of range");
  a_new_class: assert property (BOTH && byte_done && state_q == psv_pkg::PSV_ST_OFFS
    && shift_q >= psv_pkg::PSV_V2_OFFS_LO && shift_q <= psv_pkg::PSV_V2_OFFS_HI
    |=> detected_proto == psv_pkg::PSV_PROTO_V2)
    else $error("newer protocol offset out of range");
  a_gap_silent: assert property (byte_done && class_offs > psv_pkg::PSV_V1_OFFS_HI
    && class_offs < psv_pkg::PSV_V2_OFFS_LO |-> !det_event ##1 $stable(detected_proto))
    else $error("gap offset raised detection");
  a_single_quiet: assert property (!BOTH |-> !detect_irq && core_enable != 2'h0)
    else $error("single protocol build switched");
  a_status_last: assert property (det_event |=> detected_proto == $past(det_proto))
    else $error("status does not show last protocol");
  a_dev_filter: assert property (byte_done && state_q == psv_pkg::PSV_ST_ADDR
    && shift_q[7:1] != psv_pkg::PSV_DDC_DEV_ADDR && !bus_start && !bus_stop
    |=> state_q == psv_pkg::PSV_ST_IGNORE)
    else $error("foreign device not ignored");
  a_egress_path: assert property (cascade && link_tvalid |-> egress_tvalid
    && link_tready == egress_tready)
    else $error("cascade not routed through egress");
  a_stream_hold: assert property (video_tvalid && !video_tready
    |=> video_tvalid && $stable(video_tdata) && $stable(video_tlast))
    else $error("stream beat dropped under stall");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn");

  c_detect_old: cover property (det_event && det_proto == psv_pkg::PSV_PROTO_V1);
  c_detect_new: cover property (det_event && det_proto == psv_pkg::PSV_PROTO_V2);
  c_clear_irq: cover property (detect_irq ##1 !detect_irq);
  c_frame_start: cover property (video_tvalid && video_tready && video_tuser);

endmodule
`default_nettype wire
